// ===== core/hbt_defs.svh
// register map, field positions, reset values and timing of the bridge bank
`ifndef HBT_DEFS_SVH
`define HBT_DEFS_SVH

`define HBT_ADDR_CHG 7'h1A
`define HBT_ADDR_ON 7'h1B
`define HBT_ADDR_OFF 7'h1C

`define HBT_NUM_HB 3

`define HBT_DIS_MSB 15
`define HBT_DIS_LSB 10
`define HBT_CHG_MSB 9
`define HBT_CHG_LSB 4
`define HBT_DLY_MSB 13
`define HBT_DLY_LSB 8
`define HBT_SEL_MSB 2
`define HBT_SEL_LSB 0

`define HBT_DIS_RST 6'h0F
`define HBT_CHG_RST 6'h0D
`define HBT_DLY_RST 6'h0C
`define HBT_SEL_RST 3'h0
`define HBT_CHG_REG_RST 16'h3CD0
`define HBT_DLY_REG_RST 16'h0C00

// nominal delay per code step; the bank only stores the code
`define HBT_DLY_STEP_PS 53300
`define HBT_CLK_PS 10000
`define HBT_DLY_STEP_CYC (`HBT_DLY_STEP_PS / `HBT_CLK_PS)

`endif

// ===== core/hbt_pkg.sv
// types shared by the bridge timing bank
package hbt_pkg;

  typedef logic [5:0] hbt_code_t;
  typedef logic [2:0] hbt_sel_t;
  typedef logic [1:0] hbt_idx_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [15:0] wdata;
  } hbt_reg_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] rdata;
  } hbt_reg_rsp_t;

  typedef struct packed {
    hbt_code_t dis;
    hbt_code_t chg;
    hbt_code_t on;
    hbt_code_t off;
  } hbt_bridge_cfg_t;

  typedef enum logic [3:0] {
    HBT_REG_NONE = 4'h1,
    HBT_REG_CHG = 4'h2,
    HBT_REG_ON = 4'h4,
    HBT_REG_OFF = 4'h8
  } hbt_reg_e;

endpackage

// ===== core/hbt_bank_sel.sv
// bank select field of one banked register location
`timescale 1ns/100ps
`include "hbt_defs.svh"
module hbt_bank_sel
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic restart,
  input wire logic wr_en,
  input wire hbt_pkg::hbt_sel_t wr_sel,
  output hbt_pkg::hbt_sel_t sel,
  output logic sel_ok
);
  import hbt_pkg::*;

  hbt_sel_t next_sel;

  // restart and soft reset both park the select on the first bridge
  always_comb
  begin
    next_sel = sel;
    if (soft_rst || restart)
      next_sel = `HBT_SEL_RST;
    else if (wr_en)
      next_sel = wr_sel;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      sel <= `HBT_SEL_RST;
    else
      sel <= next_sel;
  end

  assign sel_ok = (sel < 3'(`HBT_NUM_HB));

endmodule

// ===== core/hbt_code_store.sv
// per-bridge storage of one 6-bit code, addressed by bridge index
`timescale 1ns/100ps
`include "hbt_defs.svh"
module hbt_code_store
#(
  parameter hbt_pkg::hbt_code_t RST_VAL = 6'h00
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic wr_en,
  input wire hbt_pkg::hbt_idx_t wr_idx,
  input wire hbt_pkg::hbt_code_t wdata,
  input wire hbt_pkg::hbt_idx_t rd_idx,
  output hbt_pkg::hbt_code_t rd_data,
  output hbt_pkg::hbt_code_t codes [`HBT_NUM_HB]
);
  import hbt_pkg::*;

  hbt_code_t mem [`HBT_NUM_HB];
  hbt_code_t next_mem [`HBT_NUM_HB];

  // restart leaves the codes alone: they keep whatever was last stored
  always_comb
  begin
    for (int i = 0; i < `HBT_NUM_HB; i++)
    begin
      if (soft_rst)
        next_mem[i] = RST_VAL;
      else if (wr_en && (wr_idx == 2'(i)))
        next_mem[i] = wdata;
      else
        next_mem[i] = mem[i];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < `HBT_NUM_HB; i++)
        mem[i] <= RST_VAL;
    end
    else
    begin
      for (int i = 0; i < `HBT_NUM_HB; i++)
        mem[i] <= next_mem[i];
    end
  end

  // index 3 has no storage behind it and reads as zero
  assign rd_data = (rd_idx < 2'(`HBT_NUM_HB)) ? mem[rd_idx] : 6'h00;
  assign codes = mem;

endmodule

// ===== core/hbt_cfg_bank.sv
// banked pre-charge and switching delay configuration for three bridges
//
// How it works
// - discharge start code in bits 15:10, one per bridge, default 0x0F.
// - charge start code in bits 9:4, one per bridge, default 0x0D.
// - charge register select field picks which bridge codes are accessed.
// - charge select 0,1,2 pick bridges one to three; 3 is reserved.
// - switch-on delay code bits 13:8 per bridge, step 53.3 ns, default 12.
// - switch-on select 0,1,2 pick bridges; 3 reserved, 4 to 7 invalid.
// - switch-off delay code bits 13:8 per bridge, step 53.3 ns, default 12.
// - switch-off select 0,1,2 pick bridges; 4 to 7 invalid.
// - reserved bits always read as zero in all three registers.
// - after power-on or soft reset charge register reads 0x3CD0.
// - restart clears charge register bits 3:0, codes are kept.
// - after power-on or soft reset both delay registers read 0x0C00.
// - restart clears delay register bits 15:14 and 7:0, codes kept.
`timescale 1ns/100ps
`include "hbt_defs.svh"
module hbt_cfg_bank
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic restart,
  input wire hbt_pkg::hbt_reg_req_t reg_req,
  output hbt_pkg::hbt_reg_rsp_t reg_rsp,
  output hbt_pkg::hbt_bridge_cfg_t hb_cfg [`HBT_NUM_HB],
  output logic sel_fault
);
  import hbt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic hbt_reg_e dec_reg(input logic [6:0] addr);
    hbt_reg_e r;
    r = HBT_REG_NONE;
    case (addr)
      `HBT_ADDR_CHG: r = HBT_REG_CHG;
      `HBT_ADDR_ON: r = HBT_REG_ON;
      `HBT_ADDR_OFF: r = HBT_REG_OFF;
      default: r = HBT_REG_NONE;
    endcase
    return r;
  endfunction

  hbt_reg_e wr_reg;
  hbt_reg_e rd_reg;
  logic wr_go;
  logic chg_wr;
  logic on_wr;
  logic off_wr;
  hbt_sel_t w_sel;
  logic w_ok;
  hbt_idx_t w_idx;

  assign wr_reg = dec_reg(reg_req.addr);
  assign rd_reg = dec_reg(reg_req.rd ? reg_req.addr : 7'h00);
  // reset and restart cycles swallow a write so the park value holds
  assign wr_go = reg_req.wr && !soft_rst && !restart;
  assign chg_wr = wr_go && (wr_reg == HBT_REG_CHG);
  assign on_wr = wr_go && (wr_reg == HBT_REG_ON);
  assign off_wr = wr_go && (wr_reg == HBT_REG_OFF);
  assign w_sel = reg_req.wdata[`HBT_SEL_MSB:`HBT_SEL_LSB];
  // a reserved or invalid select still lands in the select field, but the
  // value fields of that write have no bridge to go to and are dropped
  assign w_ok = (w_sel < 3'(`HBT_NUM_HB));
  assign w_idx = w_sel[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // bank selects

  hbt_sel_t chg_sel;
  hbt_sel_t on_sel;
  hbt_sel_t off_sel;
  logic chg_ok;
  logic on_ok;
  logic off_ok;

  hbt_bank_sel u_chg_sel (
    .clk_sys(clk_sys),
    .rst(rst),
    .soft_rst(soft_rst),
    .restart(restart),
    .wr_en(chg_wr),
    .wr_sel(w_sel),
    .sel(chg_sel),
    .sel_ok(chg_ok)
  );

  hbt_bank_sel u_on_sel (
    .clk_sys(clk_sys),
    .rst(rst),
    .soft_rst(soft_rst),
    .restart(restart),
    .wr_en(on_wr),
    .wr_sel(w_sel),
    .sel(on_sel),
    .sel_ok(on_ok)
  );

  hbt_bank_sel u_off_sel (
    .clk_sys(clk_sys),
    .rst(rst),
    .soft_rst(soft_rst),
    .restart(restart),
    .wr_en(off_wr),
    .wr_sel(w_sel),
    .sel(off_sel),
    .sel_ok(off_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // per-bridge code storage

  hbt_code_t dis_rd;
  hbt_code_t chg_rd;
  hbt_code_t on_rd;
  hbt_code_t off_rd;
  hbt_code_t dis_codes [`HBT_NUM_HB];
  hbt_code_t chg_codes [`HBT_NUM_HB];
  hbt_code_t on_codes [`HBT_NUM_HB];
  hbt_code_t off_codes [`HBT_NUM_HB];

  hbt_code_store #(.RST_VAL(`HBT_DIS_RST)) u_dis (
    .clk_sys(clk_sys),
    .rst(rst),
    .soft_rst(soft_rst),
    .wr_en(chg_wr && w_ok),
    .wr_idx(w_idx),
    .wdata(reg_req.wdata[`HBT_DIS_MSB:`HBT_DIS_LSB]),
    .rd_idx(chg_sel[1:0]),
    .rd_data(dis_rd),
    .codes(dis_codes)
  );

  hbt_code_store #(.RST_VAL(`HBT_CHG_RST)) u_chg (
    .clk_sys(clk_sys),
    .rst(rst),
    .soft_rst(soft_rst),
    .wr_en(chg_wr && w_ok),
    .wr_idx(w_idx),
    .wdata(reg_req.wdata[`HBT_CHG_MSB:`HBT_CHG_LSB]),
    .rd_idx(chg_sel[1:0]),
    .rd_data(chg_rd),
    .codes(chg_codes)
  );

  hbt_code_store #(.RST_VAL(`HBT_DLY_RST)) u_on (
    .clk_sys(clk_sys),
    .rst(rst),
    .soft_rst(soft_rst),
    .wr_en(on_wr && w_ok),
    .wr_idx(w_idx),
    .wdata(reg_req.wdata[`HBT_DLY_MSB:`HBT_DLY_LSB]),
    .rd_idx(on_sel[1:0]),
    .rd_data(on_rd),
    .codes(on_codes)
  );

  hbt_code_store #(.RST_VAL(`HBT_DLY_RST)) u_off (
    .clk_sys(clk_sys),
    .rst(rst),
    .soft_rst(soft_rst),
    .wr_en(off_wr && w_ok),
    .wr_idx(w_idx),
    .wdata(reg_req.wdata[`HBT_DLY_MSB:`HBT_DLY_LSB]),
    .rd_idx(off_sel[1:0]),
    .rd_data(off_rd),
    .codes(off_codes)
  );

  genvar g;
  generate
    for (g = 0; g < `HBT_NUM_HB; g++)
    begin : g_cfg
      assign hb_cfg[g] = '{dis_codes[g], chg_codes[g], on_codes[g],
                           off_codes[g]};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read path and fault flag

  hbt_reg_rsp_t next_rsp;
  logic next_sel_fault;

  // an unbacked select reads back with zero codes, so a stale value of
  // some other bridge can never be mistaken for the addressed one
  always_comb
  begin
    next_rsp = '0;
    next_rsp.valid = reg_req.rd;
    unique case (rd_reg)
      HBT_REG_CHG: next_rsp.rdata = {chg_ok ? dis_rd : 6'h00,
                                     chg_ok ? chg_rd : 6'h00,
                                     1'b0, chg_sel};
      HBT_REG_ON: next_rsp.rdata = {2'b00, on_ok ? on_rd : 6'h00,
                                    5'h00, on_sel};
      HBT_REG_OFF: next_rsp.rdata = {2'b00, off_ok ? off_rd : 6'h00,
                                     5'h00, off_sel};
      HBT_REG_NONE: next_rsp.rdata = 16'h0000;
    endcase
    next_sel_fault = !(chg_ok && on_ok && off_ok);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      reg_rsp <= '0;
      sel_fault <= 1'b0;
    end
    else
    begin
      reg_rsp <= next_rsp;
      sel_fault <= next_sel_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic rd_quiet;
  assign rd_quiet = reg_req.rd && !reg_req.wr && !soft_rst && !restart;
  logic [71:0] cfg_flat;
  assign cfg_flat = {hb_cfg[2], hb_cfg[1], hb_cfg[0]};

  // set by either reset, cleared by any write: while high the bank
  // must still show its reset contents
  logic dflt_hold;
  logic next_dflt_hold;
  always_comb
  begin
    next_dflt_hold = dflt_hold;
    if (soft_rst)
      next_dflt_hold = 1'b1;
    else if (reg_req.wr)
      next_dflt_hold = 1'b0;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      dflt_hold <= 1'b1;
    else
      dflt_hold <= next_dflt_hold;
  end

  a_chg_reserved:
  assert property (reg_req.rd && rd_reg == HBT_REG_CHG
                   |=> reg_rsp.valid && reg_rsp.rdata[3] == 1'b0)
    else $error("charge register reserved bit not zero");

  a_dly_reserved:
  assert property (reg_req.rd && (rd_reg == HBT_REG_ON ||
                   rd_reg == HBT_REG_OFF)
                   |=> reg_rsp.rdata[15:14] == 2'b00 &&
                       reg_rsp.rdata[7:3] == 5'h00)
    else $error("delay register reserved bits not zero");

  a_chg_por_value:
  assert property (dflt_hold && rd_quiet && rd_reg == HBT_REG_CHG
                   |=> reg_rsp.rdata == `HBT_CHG_REG_RST)
    else $error("charge register wrong after soft reset");

  a_dly_por_value:
  assert property (dflt_hold && rd_quiet && rd_reg != HBT_REG_CHG &&
                   rd_reg != HBT_REG_NONE
                   |=> reg_rsp.rdata == `HBT_DLY_REG_RST)
    else $error("delay register wrong after soft reset");

  a_soft_defaults:
  assert property (soft_rst |=> hb_cfg[2].dis == `HBT_DIS_RST &&
                   hb_cfg[1].chg == `HBT_CHG_RST &&
                   hb_cfg[0].on == `HBT_DLY_RST &&
                   hb_cfg[2].off == `HBT_DLY_RST)
    else $error("codes not at defaults after soft reset");

  a_restart_sel:
  assert property (restart && !soft_rst
                   |=> chg_sel == 3'h0 && on_sel == 3'h0 &&
                       off_sel == 3'h0 && !chg_ok == 1'b0)
    else $error("restart did not park the selects");

  a_restart_keeps:
  assert property (restart && !soft_rst |=> cfg_flat == $past(cfg_flat))
    else $error("restart changed a stored code");

  a_chg_bank_wr:
  assert property (chg_wr && w_sel == 3'h1
                   |=> hb_cfg[1].chg == $past(reg_req.wdata[9:4]) &&
                       hb_cfg[1].dis == $past(reg_req.wdata[15:10]) &&
                       hb_cfg[0] == $past(hb_cfg[0]))
    else $error("charge write missed its bridge");

  a_off_bank_wr:
  assert property (off_wr && w_sel == 3'h2
                   |=> hb_cfg[2].off == $past(reg_req.wdata[13:8]) &&
                       hb_cfg[2].on == $past(hb_cfg[2].on))
    else $error("switch-off write missed its bridge");

  a_bad_sel_drop:
  assert property (reg_req.wr && !w_ok && !soft_rst && !restart
                   |=> cfg_flat == $past(cfg_flat))
    else $error("invalid select write changed a code");

  a_on_read_sel:
  assert property (rd_quiet && rd_reg == HBT_REG_ON && on_sel == 3'h2
                   |=> reg_rsp.rdata[13:8] == $past(hb_cfg[2].on) &&
                       reg_rsp.rdata[2:0] == 3'h2)
    else $error("switch-on read not from selected bridge");

  a_fault_flag:
  assert property (on_wr && w_sel == 3'h3 ##1 !soft_rst && !restart
                   |=> sel_fault)
    else $error("reserved select not flagged");

  c_chg_write: cover property (chg_wr && w_ok ##1 rd_quiet);
  c_bad_sel: cover property (on_wr && !w_ok);
  c_restart_read: cover property (restart ##1 reg_req.rd);
  c_on_bridge3: cover property (on_wr && w_sel == 3'h2);

endmodule

// ===== tb/hbt_host_model.sv
// host side model issuing register writes and reads to the bridge bank
`timescale 1ns/100ps
module hbt_host_model
(
  input wire logic clk_sys,
  input wire hbt_pkg::hbt_reg_rsp_t reg_rsp,
  output hbt_pkg::hbt_reg_req_t reg_req
);
  import hbt_pkg::*;

  initial reg_req = '0;

  ////////////////////////////////////////////////////////////////////////////
  // idle request lines show the inverse of the last value, not a stale copy
  task automatic write_reg(input logic [6:0] addr, input logic [15:0] data);
    @(negedge clk_sys);
    reg_req.wr = 1'b1;
    reg_req.addr = addr;
    reg_req.wdata = {data[15:3], 1'b0, data[1:0]};
    @(negedge clk_sys);
    reg_req.wr = 1'b0;
    reg_req.addr = ~reg_req.addr;
    reg_req.wdata = ~reg_req.wdata;
  endtask

  // answer comes exactly one edge after the read is taken
  task automatic read_reg(input logic [6:0] addr, output logic [15:0] data,
                          output logic ok);
    @(negedge clk_sys);
    reg_req.rd = 1'b1;
    reg_req.addr = addr;
    @(negedge clk_sys);
    ok = reg_rsp.valid;
    data = reg_rsp.rdata;
    reg_req.rd = 1'b0;
    reg_req.addr = ~reg_req.addr;
  endtask
endmodule

// ===== tb/hbt_cfg_bank_tb_top.sv
// self-checking bench of the banked bridge timing registers
`timescale 1ns/100ps
`include "hbt_defs.svh"
`define CHK(nm, e, g) \
  begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %h got %h", nm, e, g); end end
module hbt_cfg_bank_tb_top;
  import hbt_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic soft_rst = 1'b0;
  logic restart = 1'b0;
  hbt_reg_req_t reg_req;
  hbt_reg_rsp_t reg_rsp;
  hbt_bridge_cfg_t hb_cfg [`HBT_NUM_HB];
  logic sel_fault;
  hbt_code_t s_dis [3];
  hbt_code_t s_chg [3];
  hbt_code_t s_on [3];
  hbt_code_t s_off [3];
  hbt_sel_t s_sel [3];
  int seed = 71;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [6:0] addrs [3] = '{`HBT_ADDR_CHG, `HBT_ADDR_ON, `HBT_ADDR_OFF};

  always #5 clk_sys = ~clk_sys;

  hbt_cfg_bank i_dut (.clk_sys(clk_sys), .rst(rst), .soft_rst(soft_rst),
    .restart(restart), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .hb_cfg(hb_cfg), .sel_fault(sel_fault));

  hbt_host_model i_host (.clk_sys(clk_sys), .reg_rsp(reg_rsp),
    .reg_req(reg_req));

  ////////////////////////////////////////////////////////////////////////////
  // shadow of the bank; a select of 3..7 shows zero codes
  function automatic logic [15:0] exp_read(input logic [6:0] a);
    int r;
    hbt_sel_t s;
    hbt_code_t c;
    r = (a == `HBT_ADDR_CHG) ? 0 : (a == `HBT_ADDR_ON) ? 1 : 2;
    s = s_sel[r];
    c = (s > 3'h2) ? 6'h00 : (r == 0) ? s_dis[s[1:0]] :
        (r == 1) ? s_on[s[1:0]] : s_off[s[1:0]];
    if (a == `HBT_ADDR_CHG)
      return {c, (s > 3'h2) ? 6'h00 : s_chg[s[1:0]], 1'b0, s};
    if (a == `HBT_ADDR_ON || a == `HBT_ADDR_OFF)
      return {2'b00, c, 5'h00, s};
    return 16'h0000;
  endfunction

  function automatic void set_defaults();
    for (int i = 0; i < 3; i++)
    begin
      s_dis[i] = 6'h0F;
      s_chg[i] = 6'h0D;
      s_on[i] = 6'h0C;
      s_off[i] = 6'h0C;
      s_sel[i] = 3'h0;
    end
  endfunction

  task automatic do_wr(input int r, input logic [15:0] d);
    hbt_sel_t s;
    s = d[2:0];
    i_host.write_reg(addrs[r], d);
    s_sel[r] = s;
    if (s <= 3'h2 && r == 0)
    begin
      s_dis[s[1:0]] = d[15:10];
      s_chg[s[1:0]] = d[9:4];
    end
    if (s <= 3'h2 && r == 1)
      s_on[s[1:0]] = d[13:8];
    if (s <= 3'h2 && r == 2)
      s_off[s[1:0]] = d[13:8];
  endtask

  task automatic chk_rd(input logic [6:0] a);
    logic [15:0] d;
    logic ok;
    i_host.read_reg(a, d, ok);
    `CHK("valid", 1'b1, ok)
    `CHK("rdata", exp_read(a), d)
  endtask

  task automatic rd_all();
    hbt_bridge_cfg_t e;
    for (int r = 0; r < 3; r++)
      chk_rd(addrs[r]);
    chk_rd(7'h1D);
    for (int i = 0; i < 3; i++)
    begin
      e = {s_dis[i], s_chg[i], s_on[i], s_off[i]};
      `CHK("hb_cfg", e, hb_cfg[i])
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // hard ceiling on run time in case the sequence stalls
  initial
  begin
    #300000;
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    logic [15:0] d;
    int r;
    set_defaults();
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    rd_all();
    $display("test reset_values done");
    // all-ones fields with reserved bits set, bridge three
    do_wr(0, 16'hFFFA);
    chk_rd(`HBT_ADDR_CHG);
    for (int k = 0; k < 90; k++)
    begin
      r = $unsigned($random(seed)) % 3;
      d = 16'($random(seed));
      d[2:0] = 3'($unsigned($random(seed)) % 3);
      do_wr(r, d);
      chk_rd(addrs[r]);
      if (k % 9 == 0)
        rd_all();
    end
    $display("test random_banks done");
    do_wr(1, 16'h3F03);
    chk_rd(`HBT_ADDR_ON);
    repeat (2) @(negedge clk_sys);
    `CHK("sel_fault", 1'b1, sel_fault)
    do_wr(1, 16'h0501);
    repeat (2) @(negedge clk_sys);
    `CHK("sel_fault", 1'b0, sel_fault)
    rd_all();
    $display("test reserved_select done");
    for (r = 0; r < 3; r++)
      do_wr(r, 16'h2A32);
    @(negedge clk_sys);
    restart = 1'b1;
    @(negedge clk_sys);
    restart = 1'b0;
    for (r = 0; r < 3; r++)
      s_sel[r] = 3'h0;
    rd_all();
    $display("test restart done");
    @(negedge clk_sys);
    soft_rst = 1'b1;
    @(negedge clk_sys);
    soft_rst = 1'b0;
    set_defaults();
    rd_all();
    $display("test soft_reset done");
    end_of_test();
  end
endmodule
